// >>> pkg/ifd_defs.svh
// opcode map, operand field positions and cycle counts of the instruction decoder
`ifndef IFD_DEFS_SVH
`define IFD_DEFS_SVH

// opcode field of every program word
`define IFD_OPC_HI 23
`define IFD_OPC_LO 16
`define IFD_ZERO_OPC 8'h00

// double-word opcodes: absolute call, absolute jump, double-word move
`define IFD_OP_CALL_ABS 8'h02
`define IFD_OP_GOTO_ABS 8'h04
`define IFD_OP_MOV_DBL 8'hbe

// single-word control opcodes
`define IFD_OP_CALL_IND 8'h01
`define IFD_OP_GOTO_IND 8'h05
`define IFD_OP_RETURN 8'h06
`define IFD_OP_RET_INT 8'h07
`define IFD_OP_BRA_LO 8'h30
`define IFD_OP_BRA_HI 8'h36
`define IFD_OP_BRA_ALW 8'h37
`define IFD_OP_TBL_LO 8'hba
`define IFD_OP_TBL_HI 8'hbb

// operation group ranges
`define IFD_OP_MOVF_LO 8'h18
`define IFD_OP_MOVF_HI 8'h1f
`define IFD_OP_MOVW_LO 8'h20
`define IFD_OP_MOVW_HI 8'h2f
`define IFD_OP_DEFAULT_WORKING_REGISTER_LO 8'h40
`define IFD_OP_DEFAULT_WORKING_REGISTER_HI 8'h5f
`define IFD_OP_LALU_LO 8'h60
`define IFD_OP_LALU_HI 8'h7f
`define IFD_OP_BIT_LO 8'ha0
`define IFD_OP_BIT_HI 8'ha7
`define IFD_OP_BSKP_LO 8'ha8
`define IFD_OP_BSKP_HI 8'haf
`define IFD_OP_FILE_LO 8'hb0
`define IFD_OP_FILE_HI 8'hb7

// opcode flag bits
`define IFD_OPB_BYTE 0
`define IFD_OPB_DST 1
`define IFD_OPB_FILE 2
`define IFD_OPB_BASE 3

// operand field positions in the low 16 bits
`define IFD_F_BASE_HI 15
`define IFD_F_BASE_LO 12
`define IFD_F_DST_HI 11
`define IFD_F_DST_LO 8
`define IFD_F_DMD_HI 7
`define IFD_F_DMD_LO 6
`define IFD_F_SRC_HI 5
`define IFD_F_SRC_LO 2
`define IFD_F_SMD_HI 1
`define IFD_F_SMD_LO 0
`define IFD_F_FILE_HI 12
`define IFD_F_FILE_LO 0
`define IFD_F_FWREG 13
`define IFD_F_LIT5_HI 10
`define IFD_F_LIT5_LO 6
`define IFD_F_TBL_HI 15
`define IFD_F_TBL_LO 14
`define IFD_F_AHI_HI 6
`define IFD_F_AHI_LO 0

// instruction cycle counts
`define IFD_CYC_ONE 2'h1
`define IFD_CYC_TWO 2'h2
`define IFD_CYC_BRANCH 2'h2
`define IFD_CYC_IND 2'h2
`define IFD_CYC_TABLE 2'h2
`define IFD_CYC_RETURN 2'h3

`endif

// >>> pkg/ifd_pkg.sv
// types shared by the instruction decoder modules
`default_nettype none
package ifd_pkg;
  typedef enum logic [3:0] {
    IFD_CL_NOP, IFD_CL_DEFAULT_WORKING_REGISTER, IFD_CL_FILE, IFD_CL_BIT, IFD_CL_BIT_SKIP,
    IFD_CL_LIT_ALU, IFD_CL_LIT_MOV, IFD_CL_BRANCH_COND, IFD_CL_BRANCH_ALWAYS,
    IFD_CL_CALL_JUMP_IND, IFD_CL_CALL_JUMP_ABS, IFD_CL_MOV_DBL, IFD_CL_TABLE,
    IFD_CL_RETURN, IFD_CL_OTHER
  } ifd_class_e;

  typedef enum {IFD_ST_FIRST, IFD_ST_SECOND, IFD_ST_SKIP, IFD_ST_SKIP_SECOND} ifd_state_e;

  typedef struct packed {
    logic valid;
    logic annul;
    logic fault;
    ifd_class_e cls;
    logic [7:0] opcode;
    logic byte_mode;
    logic [3:0] base;
    logic [3:0] src;
    logic [1:0] src_mode;
    logic [3:0] dst;
    logic [1:0] dst_mode;
    logic [12:0] file_addr;
    logic dflt_default_working_register;
    logic file_target;
    logic [3:0] bit_num;
    logic bit_from_base;
    logic [15:0] literal;
    logic [22:0] prog_addr;
    logic [1:0] table_mode;
    logic [1:0] cycles;
  } ifd_dec_s;
endpackage : ifd_pkg
`default_nettype wire

// >>> pkg/ifd_stall_if.sv
// stall handshake between the decoder and its extra-cycle counter
`default_nettype none
interface ifd_stall_if;
  logic load;
  logic [1:0] extra;
  logic busy;
  modport dec (output load, output extra, input busy);
  modport cnt (input load, input extra, output busy);
endinterface : ifd_stall_if
`default_nettype wire

// >>> verilog/ifd_cycle_count.sv
// down counter that holds fetch off while the extra no-operation cycles run
`default_nettype none
module ifd_cycle_count (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // stall handshake
  ifd_stall_if.cnt stall
);
  import ifd_pkg::*;

  logic [1:0] rem_ff;
  logic [1:0] nxt_rem;

  ////////////////////////////////////////////////////////////////////////////
  // a load only arrives while idle, so it never stacks onto a running count
  always_comb begin
    nxt_rem = rem_ff;
    if (stall.load) begin
      nxt_rem = stall.extra;
    end else if (rem_ff != 2'h0) begin
      nxt_rem = rem_ff - 2'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rem_ff <= 2'h0;
    end else begin
      rem_ff <= nxt_rem;
    end
  end

  assign stall.busy = (rem_ff != 2'h0); // nop cycles of the current instruction

  ////////////////////////////////////////////////////////////////////////////
  sequence two_nops_s;
    stall.busy [*2] ##1 !stall.busy;
  endsequence

  extra_two_a: assert property (@(posedge clk) disable iff (reset)
    stall.load && stall.extra == 2'h2 |=> two_nops_s)
    else $error("two extra cycles not held");
endmodule : ifd_cycle_count
`default_nettype wire

// >>> verilog/ifd_decoder.sv
// program word decoder with operand extraction and instruction cycle timing
`default_nettype none
`include "ifd_defs.svh"
module ifd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fetch stage
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  output logic fetch_ready,
  // condition result from the datapath for the word being fetched
  input wire logic cond_true,
  // decoded instruction
  output logic dec_valid,
  output logic dec_annul,
  output logic dec_fault,
  output ifd_pkg::ifd_class_e dec_class,
  output logic [7:0] dec_opcode,
  output logic byte_mode,
  output logic [3:0] base_source_register,
  output logic [3:0] second_source_register,
  output logic [1:0] second_source_mode,
  output logic [3:0] destination_register,
  output logic [1:0] destination_mode,
  output logic [12:0] file_addr,
  output logic default_working_register,
  output logic file_target,
  output logic [3:0] bit_num,
  output logic bit_from_base,
  output logic [15:0] literal,
  output logic [22:0] prog_addr,
  output logic [1:0] table_mode,
  output logic [1:0] instr_cycles
);
  import ifd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_rng(input logic [7:0] op, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (op >= lo) && (op <= hi);
  endfunction : in_rng

  function automatic logic is_double(input logic [7:0] op);
    is_double = (op == `IFD_OP_CALL_ABS) || (op == `IFD_OP_GOTO_ABS) ||
                (op == `IFD_OP_MOV_DBL);
  endfunction : is_double

  // opcode groups; the all-zero opcode, and so any lone second word, is a nop
  function automatic ifd_class_e classify(input logic [7:0] op);
    ifd_class_e c;
    c = IFD_CL_OTHER;
    if (op == `IFD_ZERO_OPC) c = IFD_CL_NOP;
    else if (op == `IFD_OP_CALL_ABS || op == `IFD_OP_GOTO_ABS) c = IFD_CL_CALL_JUMP_ABS;
    else if (op == `IFD_OP_MOV_DBL) c = IFD_CL_MOV_DBL;
    else if (op == `IFD_OP_CALL_IND || op == `IFD_OP_GOTO_IND) c = IFD_CL_CALL_JUMP_IND;
    else if (op == `IFD_OP_RETURN || op == `IFD_OP_RET_INT) c = IFD_CL_RETURN;
    else if (op == `IFD_OP_BRA_ALW) c = IFD_CL_BRANCH_ALWAYS;
    else if (in_rng(op, `IFD_OP_BRA_LO, `IFD_OP_BRA_HI)) c = IFD_CL_BRANCH_COND;
    else if (in_rng(op, `IFD_OP_TBL_LO, `IFD_OP_TBL_HI)) c = IFD_CL_TABLE;
    else if (in_rng(op, `IFD_OP_MOVF_LO, `IFD_OP_MOVW_HI)) c = IFD_CL_LIT_MOV;
    else if (in_rng(op, `IFD_OP_DEFAULT_WORKING_REGISTER_LO, `IFD_OP_DEFAULT_WORKING_REGISTER_HI)) c = IFD_CL_DEFAULT_WORKING_REGISTER;
    else if (in_rng(op, `IFD_OP_LALU_LO, `IFD_OP_LALU_HI)) c = IFD_CL_LIT_ALU;
    else if (in_rng(op, `IFD_OP_BIT_LO, `IFD_OP_BIT_HI)) c = IFD_CL_BIT;
    else if (in_rng(op, `IFD_OP_BSKP_LO, `IFD_OP_BSKP_HI)) c = IFD_CL_BIT_SKIP;
    else if (in_rng(op, `IFD_OP_FILE_LO, `IFD_OP_FILE_HI)) c = IFD_CL_FILE;
    classify = c;
  endfunction : classify

  // cycles of a single-word instruction
  function automatic logic [1:0] cycles_of(input ifd_class_e c, input logic cond);
    logic [1:0] n;
    n = `IFD_CYC_ONE;
    case (c)
      IFD_CL_BRANCH_ALWAYS: n = `IFD_CYC_BRANCH;
      IFD_CL_CALL_JUMP_IND: n = `IFD_CYC_IND;
      IFD_CL_TABLE: n = `IFD_CYC_TABLE;
      IFD_CL_RETURN: n = `IFD_CYC_RETURN;
      IFD_CL_BRANCH_COND: n = cond ? `IFD_CYC_TWO : `IFD_CYC_ONE;
      default: n = `IFD_CYC_ONE;
    endcase
    cycles_of = n;
  endfunction : cycles_of

  // operand fields of one word; unused fields stay zero
  function automatic ifd_dec_s decode(input logic [23:0] w, input ifd_class_e c);
    ifd_dec_s d;
    logic [7:0] op;
    d = '0;
    op = w[`IFD_OPC_HI:`IFD_OPC_LO];
    d.valid = 1'b1;
    d.cls = c;
    d.opcode = op;
    case (c)
      IFD_CL_DEFAULT_WORKING_REGISTER, IFD_CL_TABLE: begin
        d.byte_mode = op[`IFD_OPB_BYTE];
        d.base = w[`IFD_F_BASE_HI:`IFD_F_BASE_LO];
        d.src = w[`IFD_F_SRC_HI:`IFD_F_SRC_LO];
        d.src_mode = w[`IFD_F_SMD_HI:`IFD_F_SMD_LO];
        d.dst = w[`IFD_F_DST_HI:`IFD_F_DST_LO];
        d.dst_mode = w[`IFD_F_DMD_HI:`IFD_F_DMD_LO];
        if (c == IFD_CL_TABLE) d.table_mode = w[`IFD_F_TBL_HI:`IFD_F_TBL_LO];
      end
      IFD_CL_FILE: begin
        d.byte_mode = op[`IFD_OPB_BYTE];
        d.file_addr = w[`IFD_F_FILE_HI:`IFD_F_FILE_LO];
        d.dflt_default_working_register = w[`IFD_F_FWREG];
        d.file_target = ~w[`IFD_F_FWREG];
      end
      IFD_CL_BIT, IFD_CL_BIT_SKIP: begin
        d.file_target = op[`IFD_OPB_FILE];
        d.bit_from_base = op[`IFD_OPB_BASE];
        d.bit_num = w[`IFD_F_BASE_HI:`IFD_F_BASE_LO];
        d.base = w[`IFD_F_BASE_HI:`IFD_F_BASE_LO];
        d.file_addr = {1'b0, w[11:0]};
        d.src = w[`IFD_F_SRC_HI:`IFD_F_SRC_LO];
        d.src_mode = w[`IFD_F_SMD_HI:`IFD_F_SMD_LO];
      end
      IFD_CL_LIT_ALU: begin
        d.byte_mode = op[`IFD_OPB_BYTE];
        d.base = w[`IFD_F_BASE_HI:`IFD_F_BASE_LO];
        d.literal = {11'h000, w[`IFD_F_LIT5_HI:`IFD_F_LIT5_LO]};
        if (op[`IFD_OPB_DST]) begin
          d.dst = w[3:0];
          d.dst_mode = w[5:4];
        end else begin
          d.dst = d.base;
        end
      end
      IFD_CL_LIT_MOV: begin
        d.file_target = (op <= `IFD_OP_MOVF_HI);
        if (d.file_target) begin
          d.literal = {8'h00, w[15:8]};
          d.file_addr = {5'h00, w[7:0]};
        end else begin
          d.literal = w[15:0];
          d.base = op[3:0];
        end
      end
      IFD_CL_BRANCH_COND, IFD_CL_BRANCH_ALWAYS: d.literal = w[15:0];
      IFD_CL_CALL_JUMP_IND: d.src = w[`IFD_F_SRC_HI:`IFD_F_SRC_LO];
      IFD_CL_CALL_JUMP_ABS: d.prog_addr = {7'h00, w[15:0]};
      IFD_CL_MOV_DBL: d.literal = w[15:0];
      default: d.valid = 1'b1;
    endcase
    decode = d;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // decode sequence

  ifd_stall_if stall ();
  ifd_state_e state_ff, nxt_state;
  ifd_dec_s dec_ff, nxt_dec;
  logic [23:0] first_ff, nxt_first;
  logic [7:0] opc;
  logic accept;
  ifd_class_e cls;

  assign opc = fetch_word[`IFD_OPC_HI:`IFD_OPC_LO];
  assign cls = classify(opc);
  assign fetch_ready = ~stall.busy;
  assign accept = fetch_valid && fetch_ready;

  // a skipped word still costs its fetch cycle, shown as an annulled nop
  always_comb begin
    nxt_state = state_ff;
    nxt_first = first_ff;
    nxt_dec = dec_ff;
    nxt_dec.valid = 1'b0;
    stall.load = 1'b0;
    stall.extra = 2'h0;
    case (state_ff)
      IFD_ST_FIRST: begin
        if (accept && is_double(opc)) begin
          nxt_first = fetch_word;
          nxt_state = IFD_ST_SECOND;
        end else if (accept) begin
          nxt_dec = decode(fetch_word, cls);
          nxt_dec.cycles = cycles_of(cls, cond_true);
          stall.load = 1'b1;
          stall.extra = nxt_dec.cycles - 2'h1;
          if (cls == IFD_CL_BIT_SKIP && cond_true) nxt_state = IFD_ST_SKIP;
        end
      end
      IFD_ST_SECOND: begin
        if (accept) begin
          nxt_dec = decode(first_ff, classify(first_ff[`IFD_OPC_HI:`IFD_OPC_LO]));
          nxt_dec.fault = (opc != `IFD_ZERO_OPC);
          nxt_dec.cycles = `IFD_CYC_TWO;
          if (nxt_dec.cls == IFD_CL_CALL_JUMP_ABS) begin
            nxt_dec.prog_addr = {fetch_word[`IFD_F_AHI_HI:`IFD_F_AHI_LO], first_ff[15:0]};
          end else begin
            nxt_dec.base = fetch_word[3:0];
          end
          nxt_state = IFD_ST_FIRST;
        end
      end
      IFD_ST_SKIP: begin
        if (accept) begin
          nxt_dec = '0;
          nxt_dec.valid = 1'b1;
          nxt_dec.annul = 1'b1;
          nxt_dec.cls = IFD_CL_NOP;
          nxt_dec.cycles = `IFD_CYC_ONE;
          nxt_state = is_double(opc) ? IFD_ST_SKIP_SECOND : IFD_ST_FIRST;
        end
      end
      IFD_ST_SKIP_SECOND: begin
        if (accept) begin
          nxt_dec = '0;
          nxt_dec.valid = 1'b1;
          nxt_dec.annul = 1'b1;
          nxt_dec.cls = IFD_CL_NOP;
          nxt_dec.cycles = `IFD_CYC_ONE;
          nxt_state = IFD_ST_FIRST;
        end
      end
      default: nxt_state = IFD_ST_FIRST;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= IFD_ST_FIRST;
      first_ff <= 24'h000000;
      dec_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      first_ff <= nxt_first;
      dec_ff <= nxt_dec;
    end
  end

  ifd_cycle_count u_cnt (
    .clk(clk),
    .reset(reset),
    .stall(stall.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from the decode register

  assign dec_valid = dec_ff.valid;
  assign dec_annul = dec_ff.annul;
  assign dec_fault = dec_ff.fault;
  assign dec_class = dec_ff.cls;
  assign dec_opcode = dec_ff.opcode;
  assign byte_mode = dec_ff.byte_mode;
  assign base_source_register = dec_ff.base;
  assign second_source_register = dec_ff.src;
  assign second_source_mode = dec_ff.src_mode;
  assign destination_register = dec_ff.dst;
  assign destination_mode = dec_ff.dst_mode;
  assign file_addr = dec_ff.file_addr;
  assign default_working_register = dec_ff.dflt_default_working_register;
  assign file_target = dec_ff.file_target;
  assign bit_num = dec_ff.bit_num;
  assign bit_from_base = dec_ff.bit_from_base;
  assign literal = dec_ff.literal;
  assign prog_addr = dec_ff.prog_addr;
  assign table_mode = dec_ff.table_mode;
  assign instr_cycles = dec_ff.cycles;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence first_take_s;
    accept && state_ff == IFD_ST_FIRST;
  endsequence

  sequence skip_taken_s;
    first_take_s and (cls == IFD_CL_BIT_SKIP && cond_true);
  endsequence

  sequence skip_over_dbl_s;
    skip_taken_s ##1 (accept && is_double(opc));
  endsequence

  opcode_field_a: assert property (
    first_take_s and !is_double(opc) |=> dec_valid && dec_opcode == $past(opc))
    else $error("opcode field not taken from the word");

  double_hold_a: assert property (
    first_take_s and is_double(opc) |=> state_ff == IFD_ST_SECOND && !dec_valid)
    else $error("double-word first word not held");

  second_zero_a: assert property (
    accept && state_ff == IFD_ST_SECOND |=> dec_fault == ($past(opc) != 8'h00))
    else $error("second word top byte check wrong");

  lone_second_a: assert property (
    first_take_s and opc == 8'h00 |=> dec_class == IFD_CL_NOP && instr_cycles == 2'h1)
    else $error("lone second word not a nop");

  single_cycle_a: assert property (
    first_take_s and cls == IFD_CL_DEFAULT_WORKING_REGISTER |=> instr_cycles == 2'h1 && fetch_ready)
    else $error("plain instruction not one cycle");

  taken_cond_a: assert property (
    first_take_s and (cls == IFD_CL_BRANCH_COND && cond_true)
      |=> !fetch_ready && instr_cycles == 2'h2 ##1 fetch_ready)
    else $error("taken branch not two cycles");

  return_cycles_a: assert property (
    first_take_s and cls == IFD_CL_RETURN |=> !fetch_ready [*2] ##1 fetch_ready)
    else $error("return not three cycles");

  skip_dbl_a: assert property (
    skip_over_dbl_s |=> state_ff == IFD_ST_SKIP_SECOND)
    else $error("skip over double word not three cycles");

  double_cycles_a: assert property (
    accept && state_ff == IFD_ST_SECOND |=> instr_cycles == 2'h2 && fetch_ready)
    else $error("double word not two cycles");
endmodule : ifd_decoder
`default_nettype wire

// >>> tb/ifd_fetch_model.sv
// program memory fetch stage model that offers queued words to the decoder
`default_nettype none
module ifd_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fetch handshake
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [23:0] fetch_word,
  output logic cond_true
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [24:0] q[$];
  logic slow = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // queued entries carry the condition bit above the word
  function automatic void push(input logic [23:0] w, input logic c);
    q.push_back({c, w});
  endfunction : push
  // a word is held until taken; in slow mode an idle cycle follows each take
  // an idle bus shows inverted junk so a stale word can never look valid
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fetch_valid <= 1'b0;
      fetch_word <= 24'h0;
      cond_true <= 1'b0;
    end else if ((!fetch_valid || fetch_ready) && !(slow && fetch_valid) && q.size() > 0) begin
      {cond_true, fetch_word} <= q.pop_front();
      fetch_valid <= 1'b1;
    end else if (!fetch_valid || fetch_ready) begin
      fetch_valid <= 1'b0;
      fetch_word <= ~fetch_word;
      cond_true <= ~cond_true;
    end
  end
endmodule : ifd_fetch_model
`default_nettype wire

// >>> tb/test_instruction_format_and_cycle_timing.sv
// self-checking bench for the instruction decoder
`default_nettype none
module test_instruction_format_and_cycle_timing;
  import ifd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, fetch_valid, fetch_ready, cond_true, dec_valid, dec_annul, dec_fault;
  logic byte_mode, default_working_register, file_target, bit_from_base;
  logic [23:0] fetch_word;
  ifd_class_e dec_class;
  logic [7:0] dec_opcode;
  logic [3:0] base_source_register, second_source_register, destination_register, bit_num;
  logic [1:0] second_source_mode, destination_mode, table_mode, instr_cycles;
  logic [12:0] file_addr;
  logic [15:0] literal;
  logic [22:0] prog_addr;
  int num_errors = 0;
  int n_checks = 0;
  int nrec, nannul, nstall;
  ////////////////////////////////////////////////////////////////////////////////
  ifd_decoder uut (.clk(clk), .reset(reset), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready), .cond_true(cond_true),
    .dec_valid(dec_valid), .dec_annul(dec_annul), .dec_fault(dec_fault),
    .dec_class(dec_class), .dec_opcode(dec_opcode), .byte_mode(byte_mode),
    .base_source_register(base_source_register),
    .second_source_register(second_source_register),
    .second_source_mode(second_source_mode), .destination_register(destination_register),
    .destination_mode(destination_mode), .file_addr(file_addr),
    .default_working_register(default_working_register), .file_target(file_target),
    .bit_num(bit_num), .bit_from_base(bit_from_base), .literal(literal),
    .prog_addr(prog_addr), .table_mode(table_mode), .instr_cycles(instr_cycles));
  ifd_fetch_model fm (.clk(clk), .reset(reset), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .cond_true(cond_true));
  // clock of 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // records and stall cycles are counted mid-cycle, where outputs have settled
  always @(negedge clk) begin
    if (dec_valid === 1'b1) nrec++;
    if (dec_valid === 1'b1 && dec_annul === 1'b1) nannul++;
    if (fetch_ready === 1'b0) nstall++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // start a scenario: clear the counters away from the monitor's edge
  task automatic clr();
    @(posedge clk);
    nrec = 0;
    nannul = 0;
    nstall = 0;
  endtask : clr
  // wait for the fetch model to drain, then let the last stall run out
  task automatic go(input int rec, input int cyc, input int stall);
    int i;
    for (i = 0; i < 200 && (fm.q.size() > 0 || fetch_valid === 1'b1); i++) @(posedge clk);
    // a fetch stage that never drains is a failure, not a silent pass
    chk("drained", 1, i < 200);
    repeat (6) @(negedge clk);
    chk("records", rec, nrec);
    chk("instr_cycles", cyc, instr_cycles);
    chk("stall cycles", stall, nstall);
  endtask : go
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_default_working_register();
    clr();
    fm.push(24'h40_1234, 1'b0);
    fm.push(24'h41_5a6b, 1'b0);
    go(2, 1, 0);
    chk("opcode", 8'h41, dec_opcode);
    chk("class", IFD_CL_DEFAULT_WORKING_REGISTER, dec_class);
    chk("byte", 1, byte_mode);
    chk("base", 4'h5, base_source_register);
    chk("src", 4'ha, second_source_register);
    chk("src mode", 2'h3, second_source_mode);
    chk("dst", 4'ha, destination_register);
    chk("dst mode", 2'h1, destination_mode);
  endtask : s_default_working_register
  task automatic s_file_bit();
    clr();
    fm.push(24'hb2_2abc, 1'b0);
    go(1, 1, 0);
    chk("class", IFD_CL_FILE, dec_class);
    chk("file", 13'h0abc, file_addr);
    chk("to default_working_register", 1, default_working_register);
    clr();
    fm.push(24'ha4_3123, 1'b0);
    go(1, 1, 0);
    chk("class", IFD_CL_BIT, dec_class);
    chk("bit", 4'h3, bit_num);
    chk("file tgt", 1, file_target);
    chk("bit base", 0, bit_from_base);
    chk("file", 13'h0123, file_addr);
  endtask : s_file_bit
  task automatic s_literal();
    clr();
    fm.push(24'h62_3166, 1'b0);
    go(1, 1, 0);
    chk("class", IFD_CL_LIT_ALU, dec_class);
    chk("base", 4'h3, base_source_register);
    chk("dst", 4'h6, destination_register);
    chk("dst mode", 2'h2, destination_mode);
    clr();
    fm.push(24'h60_3166, 1'b0);
    go(1, 1, 0);
    chk("dst", 4'h3, destination_register);
    clr();
    fm.push(24'h18_5a33, 1'b0);
    go(1, 1, 0);
    chk("class", IFD_CL_LIT_MOV, dec_class);
    chk("literal", 16'h005a, literal);
    chk("file", 13'h0033, file_addr);
    // literal move into a working register named by the opcode's low bits
    clr();
    fm.push(24'h25_beef, 1'b0);
    go(1, 1, 0);
    chk("file tgt", 0, file_target);
    chk("base", 4'h5, base_source_register);
    chk("literal", 16'hbeef, literal);
  endtask : s_literal
  // every control opcode that always stalls except 8'hbb, paced slowly by the fetch stage
  task automatic s_control();
    logic [7:0] op[6] = '{8'h06, 8'h07, 8'h37, 8'h01, 8'h05, 8'hba};
    ifd_class_e cl[6] = '{IFD_CL_RETURN, IFD_CL_RETURN, IFD_CL_BRANCH_ALWAYS,
      IFD_CL_CALL_JUMP_IND, IFD_CL_CALL_JUMP_IND, IFD_CL_TABLE};
    int cy[6] = '{3, 3, 2, 2, 2, 2};
    int k;
    fm.slow = 1'b1;
    for (k = 0; k < 6; k++) begin
      clr();
      fm.push({op[k], 16'hc000}, 1'b0);
      go(1, cy[k], cy[k] - 1);
      chk("class", cl[k], dec_class);
    end
    chk("tbl mode", 2'h3, table_mode);
    fm.slow = 1'b0;
    clr();
    fm.push(24'h33_0010, 1'b1);
    go(1, 2, 1);
    chk("class", IFD_CL_BRANCH_COND, dec_class);
    clr();
    fm.push(24'h33_0010, 1'b0);
    go(1, 1, 0);
    // an unlisted opcode ignores the condition and stays one cycle
    clr();
    fm.push(24'h90_0000, 1'b1);
    go(1, 1, 0);
    chk("class", IFD_CL_OTHER, dec_class);
  endtask : s_control
  task automatic s_double();
    clr();
    fm.push(24'h04_1234, 1'b0);
    fm.push(24'h00_0055, 1'b0);
    go(1, 2, 0);
    chk("class", IFD_CL_CALL_JUMP_ABS, dec_class);
    chk("addr", {9'h0, 7'h55, 16'h1234}, prog_addr);
    chk("fault", 0, dec_fault);
    clr();
    fm.push(24'h02_beef, 1'b0);
    fm.push(24'h01_0000, 1'b0);
    go(1, 2, 0);
    chk("fault", 1, dec_fault);
    clr();
    fm.push(24'hbe_cafe, 1'b0);
    fm.push(24'h00_0007, 1'b0);
    go(1, 2, 0);
    chk("class", IFD_CL_MOV_DBL, dec_class);
    chk("literal", 16'hcafe, literal);
    chk("base", 4'h7, base_source_register);
    clr();
    fm.push(24'h00_0042, 1'b0);
    go(1, 1, 0);
    chk("class", IFD_CL_NOP, dec_class);
  endtask : s_double
  task automatic s_skip();
    clr();
    fm.push(24'ha8_0000, 1'b1);
    fm.push(24'h40_1111, 1'b0);
    go(2, 1, 0);
    chk("annulled", 1, nannul);
    clr();
    fm.push(24'ha9_0000, 1'b1);
    fm.push(24'h02_0000, 1'b0);
    fm.push(24'h00_0001, 1'b0);
    go(3, 1, 0);
    chk("annulled", 2, nannul);
    clr();
    fm.push(24'ha8_0000, 1'b0);
    fm.push(24'h40_1111, 1'b0);
    go(2, 1, 0);
    chk("annulled", 0, nannul);
  endtask : s_skip
  // a reset in the middle of a return's stall drops the stall and the record
  task automatic s_reset();
    int i;
    clr();
    fm.push(24'h06_0000, 1'b0);
    for (i = 0; i < 20 && fetch_ready !== 1'b0; i++) @(negedge clk);
    chk("stall seen", 0, fetch_ready);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("reset ready", 1, fetch_ready);
    chk("reset valid", 0, dec_valid);
    chk("reset cycles", 0, instr_cycles);
  endtask : s_reset
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("idle valid", 0, dec_valid);
    chk("idle ready", 1, fetch_ready);
    s_default_working_register();
    s_file_bit();
    s_literal();
    s_control();
    s_double();
    s_skip();
    s_reset();
    end_of_test();
  end
endmodule : test_instruction_format_and_cycle_timing
`default_nettype wire
